// ---- rtl/afp_pkg.sv ----
/*
 * shared constants, types and register map for the host api frame parser.
 * assumes one 50 MHz clock; all users import the whole package.
 */
package afp_pkg;

   // frame framing bytes and frame types
   localparam logic [7:0] AFP_DELIM = 8'h7E;        // start of every frame
   localparam logic [7:0] AFP_FT_TX16 = 8'h01;      // 16-bit addressed send
   localparam logic [7:0] AFP_FT_CMD = 8'h08;       // local parameter command
   localparam logic [7:0] AFP_FT_TX_STATUS = 8'h89; // answer to a send
   localparam logic [7:0] AFP_FT_CMD_RESP = 8'h88;  // answer to a command
   localparam logic [7:0] AFP_CSUM_TOTAL = 8'hFF;   // body sum plus checksum
   localparam logic [15:0] AFP_BCAST_ADDR = 16'hFFFF;

   // transmit option flags
   localparam int AFP_OPT_NOACK_BIT = 0;
   localparam int AFP_OPT_BPAN_BIT = 2;
   localparam logic [7:0] AFP_OPT_LEGAL = 8'h05;    // only bits 0 and 2

   // byte offsets inside a frame
   localparam logic [15:0] AFP_OFS_TYPE = 16'h0003;
   localparam logic [15:0] AFP_OFS_ID = 16'h0004;
   localparam logic [15:0] AFP_OFS_HI = 16'h0005;
   localparam logic [15:0] AFP_OFS_LO = 16'h0006;
   localparam logic [15:0] AFP_OFS_OPT = 16'h0007;
   localparam logic [15:0] AFP_OFS_VAL = 16'h0007;
   localparam logic [15:0] AFP_OFS_PAY = 16'h0008;

   // fixed header sizes counted by the length field, and the largest value size
   localparam logic [15:0] AFP_TX_HDR_LEN = 16'h0005;
   localparam logic [15:0] AFP_CMD_HDR_LEN = 16'h0004;
   localparam logic [15:0] AFP_VAL_MAX_BYTES = 16'h0004;

   // answer status codes
   localparam logic [7:0] AFP_ST_SUCCESS = 8'h00;
   localparam logic [7:0] AFP_ST_FAILURE = 8'h01;

   // payload buffer shape: {drop, last, byte}
   localparam int AFP_FIFO_W = 10;
   localparam int AFP_FIFO_D = 8;

   // register map, byte addresses
   localparam logic [7:0] AFP_REG_CTRL = 8'h00;
   localparam logic [7:0] AFP_REG_MAXPL = 8'h04;
   localparam logic [7:0] AFP_REG_STAT = 8'h08;
   localparam logic [7:0] AFP_REG_CNT = 8'h0C;
   localparam logic [7:0] AFP_REG_LAST = 8'h10;
   localparam logic [31:0] AFP_CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] AFP_MAXPL_RST = 32'h0000_0064;
   localparam int AFP_CTRL_EN_BIT = 0;

   // parser states, one-hot
   typedef enum logic [7:0] {
      AFP_S_HUNT = 8'b0000_0001,
      AFP_S_LENH = 8'b0000_0010,
      AFP_S_LENL = 8'b0000_0100,
      AFP_S_BODY = 8'b0000_1000,
      AFP_S_CSUM = 8'b0001_0000,
      AFP_S_TXW = 8'b0010_0000,
      AFP_S_PARW = 8'b0100_0000,
      AFP_S_RESP = 8'b1000_0000
   } afp_state_e;

   // transmit request handed to the radio path
   typedef struct packed {
      logic [15:0] dest;
      logic bcast;
      logic no_ack;
      logic bcast_pan;
      logic [15:0] pay_len;
   } afp_tx_req_s;

   // one payload buffer word
   typedef struct packed {
      logic drop;
      logic last;
      logic [7:0] data;
   } afp_pl_word_s;

   // answer frame contents for the serial transmit side
   typedef struct packed {
      logic [7:0] ftype;
      logic [7:0] fid;
      logic [7:0] status;
      logic [15:0] cmd;
      logic [31:0] value;
   } afp_rsp_s;

endpackage

// ---- rtl/afp_fifo.sv ----
/*
 * shift-down fifo with valid/ready on both sides; the head sits in slot 0
 * so the read data comes straight from a flip-flop.
 * assumes one clock and an active-low asynchronous reset.
 */
module afp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int CW = $clog2(DEPTH) + 1;
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH]; // storage, slot 0 is the head
   logic [CW-1:0] count_r;          // words held
   logic push;
   logic pop;
   logic [CW-1:0] wr_slot;          // slot the incoming word lands in
   logic [CW-1:0] count_nxt;

   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign wr_slot = count_r - CW'(pop);
   assign count_nxt = count_r + CW'(push) - CW'(pop);
   assign out_data_o = mem_r[0];
   assign level_o = count_r;

   // each slot shifts down on a pop and takes the new word at its slot
   for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      logic [WIDTH-1:0] above;
      if (i < DEPTH - 1) begin : g_mid
         assign above = mem_r[i+1];
      end else begin : g_top
         assign above = mem_r[i];
      end
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            mem_r[i] <= '0;
         end else if (push && wr_slot == CW'(i)) begin
            mem_r[i] <= in_data_i;
         end else if (pop) begin
            mem_r[i] <= above;
         end
      end
   end

   // count and the flag flops; flags look at the next count
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_r <= '0;
         out_valid_o <= 1'b0;
         in_ready_o <= 1'b1;
      end else begin
         count_r <= count_nxt;
         out_valid_o <= (count_nxt != '0);
         in_ready_o <= (count_nxt != FULL);
      end
   end
endmodule

// ---- rtl/afp_frame_parser.sv ----
/*
 * host api frame parser: takes the host byte stream, checks delimiter,
 * length and checksum, decodes 16-bit send and local command requests,
 * drives the radio path, the parameter store and the answer channel.
 * assumes host bytes synchronous to mclk_i and a classic wishbone master.
 */
// Function
// - frame starts with one delimiter byte
// - 16-bit length counts bytes between length, checksum
// - checksum is 0xFF minus body byte sum
// - type 0x01 means 16-bit addressed send
// - type 0x08 means local parameter command
// - answer echoes the request frame identifier
// - zero frame identifier suppresses any answer
// - destination 0xFFFF selects broadcast
// - option bits 0 and 2 only, rest zero
// - payload from offset 8, within max payload
// - send answered with 0x89 success or failure
// - command name is two bytes at offsets 5,6
// - value bytes written to store, applied at once
// - no value bytes means query current value
// - command answered with 0x88 carrying identifier
// - set answer reports success or failure
module afp_frame_parser
   import afp_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // host byte stream
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   output logic rx_ready_o,
   // radio transmit path
   output logic tx_req_o,
   output afp_tx_req_s tx_hdr_o,
   input wire logic tx_done_i,
   input wire logic tx_fail_i,
   output logic pl_valid_o,
   output afp_pl_word_s pl_word_o,
   input wire logic pl_ready_i,
   // parameter store
   output logic par_rd_o,
   output logic par_wr_o,
   output logic [15:0] par_cmd_o,
   output logic [31:0] par_wdata_o,
   output logic [2:0] par_wlen_o,
   input wire logic par_ack_i,
   input wire logic par_fail_i,
   input wire logic [31:0] par_rdata_i,
   // answer channel
   output logic rsp_valid_o,
   output afp_rsp_s rsp_o,
   input wire logic rsp_ready_i,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   localparam int LW = $clog2(AFP_FIFO_D) + 1;
   localparam logic [LW:0] ROOM_MAX = (LW+1)'(AFP_FIFO_D - 2);

   afp_state_e state_r;      // parser state
   logic [15:0] len_r;       // length field of current frame
   logic [15:0] rem_r;       // body bytes still to come
   logic [15:0] idx_r;       // frame offset of the next body byte
   logic [7:0] sum_r;        // running body sum
   logic [7:0] ftype_r;      // frame type
   logic [7:0] fid_r;        // frame identifier
   logic [15:0] addr_r;      // destination or command name
   logic [7:0] opt_r;        // transmit options
   logic [31:0] val_r;       // parameter value, shifted in
   logic [7:0] hold_r;       // last payload byte, held until checksum
   logic hold_v_r;
   logic [31:0] ctrl_r;      // enable bit
   logic [31:0] maxpl_r;     // largest payload accepted
   logic [15:0] good_cnt_r;  // frames acted on
   logic [15:0] bad_cnt_r;   // frames dropped
   logic [23:0] last_r;      // type, id, status of last finished frame

   // payload buffer wires
   logic fifo_push;
   logic fifo_in_ready;
   afp_pl_word_s fifo_word;
   logic [LW-1:0] fifo_level;

   // decode helpers
   logic take;
   logic pay_byte;
   logic csum_take;
   logic csum_ok;
   logic len_ok;
   logic frame_ok;
   logic [15:0] tx_pay_len;
   logic [15:0] val_len;
   logic tx_good;
   logic cmd_good;
   logic exec_fail;
   logic fin_now;
   logic [7:0] fin_status;
   logic [7:0] fin_ftype;
   logic [LW:0] level_after;
   logic wb_req;
   logic wr_ctrl;
   logic wr_maxpl;
   logic wr_cnt;

   // merge a bus write into a register under its byte lane selects
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wdat,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = wdat[8*b +: 8];
         end
      end
      return res;
   endfunction

   assign take = rx_valid_i & rx_ready_o;
   // payload is every send body byte from offset 8 up to the checksum
   assign pay_byte = take && state_r == AFP_S_BODY &&
                     ftype_r == AFP_FT_TX16 && idx_r >= AFP_OFS_PAY;
   assign csum_take = take && state_r == AFP_S_CSUM;
   // body sum plus checksum byte must land on 0xFF
   assign csum_ok = 8'(sum_r + rx_data_i) == AFP_CSUM_TOTAL;
   assign tx_pay_len = len_r - AFP_TX_HDR_LEN;
   assign val_len = len_r - AFP_CMD_HDR_LEN;
   // the length must at least cover the header of the decoded type
   always_comb begin
      len_ok = 1'b0;
      if (ftype_r == AFP_FT_TX16) begin
         len_ok = len_r >= AFP_TX_HDR_LEN;
      end else if (ftype_r == AFP_FT_CMD) begin
         len_ok = len_r >= AFP_CMD_HDR_LEN;
      end
   end
   assign frame_ok = csum_ok && len_ok;
   // reserved option bits or an oversize payload fail the send
   assign tx_good = ((opt_r & ~AFP_OPT_LEGAL) == 8'h00) &&
                    (tx_pay_len <= maxpl_r[15:0]);
   // values wider than the store's word are refused
   assign cmd_good = val_len <= AFP_VAL_MAX_BYTES;
   assign exec_fail = csum_take && frame_ok &&
                      (ftype_r == AFP_FT_TX16 ? !tx_good : !cmd_good);
   assign fin_now = exec_fail || (state_r == AFP_S_TXW && tx_done_i) ||
                    (state_r == AFP_S_PARW && par_ack_i);

   // outcome of the finishing request, for the answer and for software
   always_comb begin
      if (exec_fail) begin
         fin_status = AFP_ST_FAILURE;
      end else if (state_r == AFP_S_TXW) begin
         fin_status = tx_fail_i ? AFP_ST_FAILURE : AFP_ST_SUCCESS;
      end else begin
         fin_status = par_fail_i ? AFP_ST_FAILURE : AFP_ST_SUCCESS;
      end
      fin_ftype = (ftype_r == AFP_FT_TX16) ? AFP_FT_TX_STATUS
                                           : AFP_FT_CMD_RESP;
   end

   // the last payload byte waits for the checksum so it can carry the verdict
   assign fifo_push = (pay_byte && hold_v_r) || (csum_take && hold_v_r);
   always_comb begin
      fifo_word.data = hold_r;
      fifo_word.last = csum_take;
      fifo_word.drop = csum_take && !(frame_ok && tx_good);
   end

   afp_fifo #(
      .WIDTH(AFP_FIFO_W),
      .DEPTH(AFP_FIFO_D)
   ) u_pl_fifo (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(fifo_push),
      .in_data_i(fifo_word),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(pl_valid_o),
      .out_data_o(pl_word_o),
      .out_ready_i(pl_ready_i),
      .level_o(fifo_level)
   );

   // fill after this cycle; ready is registered so keep one spare slot
   assign level_after = (LW+1)'(fifo_level) + (LW+1)'(fifo_push) -
                        (LW+1)'(pl_valid_o & pl_ready_i);

   // host ready: only while parsing and with room; a stalled radio
   // path therefore stalls the host
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_ready_o <= 1'b0;
      end else begin
         rx_ready_o <= fifo_in_ready && level_after <= ROOM_MAX &&
                       (state_r inside {AFP_S_HUNT, AFP_S_LENH, AFP_S_LENL,
                                        AFP_S_BODY} ||
                        (state_r == AFP_S_CSUM && !take));
      end
   end

   // frame state machine
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= AFP_S_HUNT;
      end else begin
         unique case (state_r)
            AFP_S_HUNT: begin
               // anything but a delimiter is skipped; disabled drops all
               if (take && rx_data_i == AFP_DELIM &&
                   ctrl_r[AFP_CTRL_EN_BIT]) begin
                  state_r <= AFP_S_LENH;
               end
            end
            AFP_S_LENH: begin
               if (take) begin
                  state_r <= AFP_S_LENL;
               end
            end
            AFP_S_LENL: begin
               // an empty body cannot hold a frame type
               if (take) begin
                  state_r <= ({len_r[15:8], rx_data_i} == 16'h0000) ?
                             AFP_S_HUNT : AFP_S_BODY;
               end
            end
            AFP_S_BODY: begin
               if (take && rem_r == 16'h0001) begin
                  state_r <= AFP_S_CSUM;
               end
            end
            AFP_S_CSUM: begin
               if (take) begin
                  if (!frame_ok) begin
                     state_r <= AFP_S_HUNT;
                  end else if (exec_fail) begin
                     state_r <= (fid_r != 8'h00) ? AFP_S_RESP
                                                 : AFP_S_HUNT;
                  end else if (ftype_r == AFP_FT_TX16) begin
                     state_r <= AFP_S_TXW;
                  end else begin
                     state_r <= AFP_S_PARW;
                  end
               end
            end
            AFP_S_TXW, AFP_S_PARW: begin
               if (fin_now) begin
                  state_r <= (fid_r != 8'h00) ? AFP_S_RESP
                                              : AFP_S_HUNT;
               end
            end
            AFP_S_RESP: begin
               if (rsp_ready_i) begin
                  state_r <= AFP_S_HUNT;
               end
            end
            default: begin
               state_r <= AFP_S_HUNT;
            end
         endcase
      end
   end

   // field capture, all multi-byte fields high byte first
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         len_r <= '0;
         rem_r <= '0;
         idx_r <= '0;
         sum_r <= '0;
         ftype_r <= '0;
         fid_r <= '0;
         addr_r <= '0;
         opt_r <= '0;
         val_r <= '0;
      end else if (take) begin
         if (state_r == AFP_S_LENH) begin
            len_r[15:8] <= rx_data_i;
         end else if (state_r == AFP_S_LENL) begin
            len_r[7:0] <= rx_data_i;
            rem_r <= {len_r[15:8], rx_data_i};
            idx_r <= AFP_OFS_TYPE;
            sum_r <= '0;
            val_r <= '0;
            opt_r <= '0;
            ftype_r <= '0;
         end else if (state_r == AFP_S_BODY) begin
            rem_r <= rem_r - 16'h0001;
            idx_r <= idx_r + 16'h0001;
            sum_r <= sum_r + rx_data_i;
            if (idx_r == AFP_OFS_TYPE) begin
               ftype_r <= rx_data_i;
            end else if (idx_r == AFP_OFS_ID) begin
               fid_r <= rx_data_i;
            end else if (idx_r == AFP_OFS_HI) begin
               addr_r[15:8] <= rx_data_i;
            end else if (idx_r == AFP_OFS_LO) begin
               addr_r[7:0] <= rx_data_i;
            end else if (ftype_r == AFP_FT_TX16 && idx_r == AFP_OFS_OPT) begin
               opt_r <= rx_data_i;
            end else if (ftype_r == AFP_FT_CMD && idx_r >= AFP_OFS_VAL) begin
               val_r <= {val_r[23:0], rx_data_i};
            end
         end
      end
   end

   // payload hold byte
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hold_r <= '0;
         hold_v_r <= 1'b0;
      end else if (pay_byte) begin
         hold_r <= rx_data_i;
         hold_v_r <= 1'b1;
      end else if (csum_take || state_r == AFP_S_HUNT) begin
         hold_v_r <= 1'b0;
      end
   end

   // one-cycle requests to the radio path and the parameter store
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_req_o <= 1'b0;
         tx_hdr_o <= '0;
         par_rd_o <= 1'b0;
         par_wr_o <= 1'b0;
         par_cmd_o <= '0;
         par_wdata_o <= '0;
         par_wlen_o <= '0;
      end else begin
         tx_req_o <= 1'b0;
         par_rd_o <= 1'b0;
         par_wr_o <= 1'b0;
         if (csum_take && frame_ok && !exec_fail) begin
            if (ftype_r == AFP_FT_TX16) begin
               tx_req_o <= 1'b1;
               tx_hdr_o.dest <= addr_r;
               tx_hdr_o.bcast <= (addr_r == AFP_BCAST_ADDR);
               tx_hdr_o.no_ack <= opt_r[AFP_OPT_NOACK_BIT];
               tx_hdr_o.bcast_pan <= opt_r[AFP_OPT_BPAN_BIT];
               tx_hdr_o.pay_len <= tx_pay_len;
            end else begin
               // a value present means set and apply now, else query
               par_cmd_o <= addr_r;
               par_wdata_o <= val_r;
               par_wlen_o <= val_len[2:0];
               par_wr_o <= (val_len != 16'h0000);
               par_rd_o <= (val_len == 16'h0000);
            end
         end
      end
   end

   // answer frame, held until the serial side takes it
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rsp_valid_o <= 1'b0;
         rsp_o <= '0;
      end else if (fin_now && fid_r != 8'h00) begin
         rsp_valid_o <= 1'b1;
         rsp_o.ftype <= fin_ftype;
         rsp_o.fid <= fid_r;
         rsp_o.status <= fin_status;
         rsp_o.cmd <= (ftype_r == AFP_FT_CMD) ? addr_r : 16'h0000;
         rsp_o.value <= (state_r == AFP_S_PARW &&
                         val_len == 16'h0000) ? par_rdata_i
                                              : 32'h0000_0000;
      end else if (rsp_valid_o && rsp_ready_i) begin
         rsp_valid_o <= 1'b0;
      end
   end

   // wishbone decode; answer one cycle after the request appears
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctrl = wb_req && wb_we_i && wb_adr_i == AFP_REG_CTRL;
   assign wr_maxpl = wb_req && wb_we_i && wb_adr_i == AFP_REG_MAXPL;
   assign wr_cnt = wb_req && wb_we_i && wb_adr_i == AFP_REG_CNT;

   // ack and read data; unmapped addresses ack and read zero
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
               AFP_REG_CTRL: wb_dat_o <= ctrl_r;
               AFP_REG_MAXPL: wb_dat_o <= maxpl_r;
               AFP_REG_STAT: wb_dat_o <= {19'h0_0000, hold_v_r,
                                          fifo_level, state_r};
               AFP_REG_CNT: wb_dat_o <= {bad_cnt_r, good_cnt_r};
               AFP_REG_LAST: wb_dat_o <= {8'h00, last_r};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // writable control registers
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_r <= AFP_CTRL_RST;
         maxpl_r <= AFP_MAXPL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= lane_merge(ctrl_r, wb_dat_i, wb_sel_i);
         end
         if (wr_maxpl) begin
            maxpl_r <= lane_merge(maxpl_r, wb_dat_i, wb_sel_i);
         end
      end
   end

   // frame counters; a count in the clearing cycle survives the clear
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         good_cnt_r <= '0;
         bad_cnt_r <= '0;
         last_r <= '0;
      end else begin
         good_cnt_r <= (wr_cnt ? 16'h0000 : good_cnt_r) + 16'(fin_now);
         bad_cnt_r <= (wr_cnt ? 16'h0000 : bad_cnt_r) +
                      16'(csum_take && !frame_ok) +
                      16'(take && state_r == AFP_S_LENL &&
                          {len_r[15:8], rx_data_i} == 16'h0000);
         if (fin_now) begin
            last_r <= {fin_ftype, fid_r, fin_status};
         end
      end
   end
endmodule

// ---- testbench/afp_frame_parser_checker.sv ----
/* port checker for the frame parser, bound at the foot.
   assumes one clock domain and the active-low async reset. */
module afp_frame_parser_checker import afp_pkg::*; (
   input wire logic mclk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_ack_o,
   input wire logic tx_req_o, rsp_valid_o, rsp_ready_i, par_wr_o,
   input wire logic [2:0] par_wlen_o,
   input wire afp_tx_req_s tx_hdr_o,
   input wire afp_rsp_s rsp_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // bus answer comes one cycle after the request and lasts one cycle
   a_wb_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing off");
   a_tx_pulse: assert property (tx_req_o |=> !tx_req_o)
      else $error("send request longer than one cycle");
   a_bcast_dest: assert property (tx_req_o |->
      tx_hdr_o.bcast == (tx_hdr_o.dest == AFP_BCAST_ADDR))
      else $error("broadcast flag disagrees with address");
   a_rsp_fid: assert property (rsp_valid_o |-> rsp_o.fid != 8'h00)
      else $error("answer sent for a zero identifier");
   a_rsp_kind: assert property (rsp_valid_o |->
      (rsp_o.ftype == AFP_FT_TX_STATUS || rsp_o.ftype == AFP_FT_CMD_RESP)
      && rsp_o.status <= AFP_ST_FAILURE) else $error("bad answer type");
   a_rsp_hold: assert property (rsp_valid_o && !rsp_ready_i
      |=> rsp_valid_o && $stable(rsp_o)) else $error("answer not held");
   a_rsp_drop: assert property (rsp_valid_o && rsp_ready_i |=> !rsp_valid_o)
      else $error("answer not released");
   a_wlen_range: assert property (par_wr_o |->
      par_wlen_o >= 3'h1 && par_wlen_o <= 3'h4) else $error("bad length");
   c_set: cover property (par_wr_o);
   c_txs: cover property (rsp_valid_o && rsp_o.ftype == AFP_FT_TX_STATUS);
   c_bc: cover property (tx_req_o && tx_hdr_o.bcast);
endmodule
bind afp_frame_parser afp_frame_parser_checker u_chk (.mclk_i, .reset_n_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_req_o, .rsp_valid_o, .rsp_ready_i,
   .par_wr_o, .par_wlen_o, .tx_hdr_o, .rsp_o);

// ---- testbench/afp_host_model.sv ----
/* host stand-in: sends whole frames byte by byte over valid/ready.
   assumes send is called right after a rising clock edge. */
module afp_host_model (
   input wire logic mclk_i,
   input wire logic rx_ready_i,
   output logic rx_valid_o = 1'b0,
   output logic [7:0] rx_data_o = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // delimiter, length high first, body, checksum, in order
   task automatic send(input logic [7:0] q[$]);
      foreach (q[i]) begin
         rx_valid_o <= 1'b1;
         rx_data_o <= q[i];
         @(posedge mclk_i);
         while (rx_ready_i !== 1'b1) @(posedge mclk_i);
      end
      rx_valid_o <= 1'b0;
      // released line must not look like a held byte
      rx_data_o <= ~rx_data_o;
   endtask
endmodule

// ---- testbench/tb_afp_frame_parser.sv ----
/* self-checking bench for the frame parser.
   assumes the host model and checker files are compiled first. */
module tb_afp_frame_parser import afp_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [63:0] b; logic [7:0] n, ft, st;} afp_row_s;
   logic mclk_i = 1'b0, reset_n_i = 1'b0, rx_valid_i, rx_ready_o, tx_req_o;
   logic tx_done_i = 1'b0, pl_valid_o, par_rd_o, par_wr_o, rsp_valid_o;
   logic par_ack_i = 1'b0, par_fail_i = 1'b0, wb_ack_o;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] rx_data_i, wb_adr_i = 8'h00;
   logic [15:0] par_cmd_o;
   logic [31:0] par_wdata_o, wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic [2:0] par_wlen_o;
   logic [3:0] wb_sel_i = 4'h0;
   afp_tx_req_s tx_hdr_o;
   afp_pl_word_s pl_word_o;
   afp_rsp_s rsp_o;
   int mismatches = 0, n_checks = 0;
   // body bytes from the top, count, answer type, status
   afp_row_s rows[6] = '{
      '{64'h0187_1234_0054_7800, 8'h07, AFP_FT_TX_STATUS, AFP_ST_SUCCESS},
      '{64'h0121_1234_0241_0000, 8'h06, AFP_FT_TX_STATUS, AFP_ST_FAILURE},
      '{64'h0133_FFFF_0542_0000, 8'h06, AFP_FT_TX_STATUS, AFP_ST_FAILURE},
      '{64'h0817_5450_0000_0000, 8'h04, AFP_FT_CMD_RESP, AFP_ST_SUCCESS},
      '{64'h08A1_4E49_4500_0000, 8'h05, AFP_FT_CMD_RESP, AFP_ST_FAILURE},
      '{64'h0853_4244_0700_0000, 8'h05, AFP_FT_CMD_RESP, AFP_ST_SUCCESS}};
   always #10 mclk_i = ~mclk_i;
   afp_host_model u_host (.mclk_i, .rx_ready_i(rx_ready_o),
      .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));
   afp_frame_parser u_dut (.mclk_i, .reset_n_i, .rx_valid_i, .rx_data_i,
      .rx_ready_o, .tx_req_o, .tx_hdr_o, .tx_done_i,
      .tx_fail_i(tx_hdr_o.bcast),
      .pl_valid_o, .pl_word_o, .pl_ready_i(1'b1), .par_rd_o, .par_wr_o,
      .par_cmd_o, .par_wdata_o, .par_wlen_o, .par_ack_i, .par_fail_i,
      .par_rdata_i(32'h0000_0029), .rsp_valid_o, .rsp_o, .rsp_ready_i(1'b1),
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_dat_o, .wb_ack_o);
   // radio and store answer next cycle; broadcasts and one name fail
   always @(posedge mclk_i) begin
      tx_done_i <= tx_req_o;
      par_ack_i <= par_rd_o | par_wr_o;
      par_fail_i <= par_wr_o && par_cmd_o == 16'h4E49;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input bit we, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      @(posedge mclk_i);
      while (wb_ack_o !== 1'b1) @(posedge mclk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   // frames a body, waits up to 40 cycles for an answer, then checks it
   task automatic run(input afp_row_s r, input logic [7:0] bad);
      logic [7:0] q[$];
      logic [7:0] s;
      int k;
      q = {AFP_DELIM, 8'h00, r.n};
      s = 8'h00;
      for (int i = 0; i < r.n; i++) begin
         q.push_back(r.b[63-8*i -: 8]);
         s += r.b[63-8*i -: 8];
      end
      q.push_back(8'hFF - s + bad);
      u_host.send(q);
      k = 0;
      while (rsp_valid_o !== 1'b1 && k < 40) begin
         @(posedge mclk_i);
         k++;
      end
      chk(k < 40, r.ft != 8'h00 && bad == 8'h00);
      if (k < 40) chk({rsp_o.ftype, rsp_o.fid, rsp_o.status},
         {r.ft, r.b[55:48], r.st});
      if (k < 40 && r.n == 8'h04) chk(rsp_o.value, 32'h0000_0029);
      @(posedge mclk_i);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk_i);
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      foreach (rows[i]) run(rows[i], 8'h00);
      wb(1'b0, AFP_REG_MAXPL, 32'h0000_0000);
      chk(rd, AFP_MAXPL_RST);
      wb(1'b0, 8'h20, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      run('{64'h0100_FFFF_0042_0000, 8'h06, 8'h00, 8'h00}, 8'h00);
      run(rows[0], 8'h01);
      wb(1'b0, AFP_REG_CNT, 32'h0000_0000);
      chk(rd, 32'h0001_0007);
      wb(1'b1, AFP_REG_MAXPL, 32'h0000_0002);
      run('{64'h0144_0001_00AA_BBCC, 8'h08, AFP_FT_TX_STATUS,
         AFP_ST_FAILURE}, 8'h00);
      wb(1'b1, AFP_REG_CTRL, 32'h0000_0000);
      run('{rows[0].b, 8'h07, 8'h00, 8'h00}, 8'h00);
      report_and_stop();
   end
endmodule
